//--- hdl/tic_capture.sv
/*
  Two-channel input capture and period-count unit with APB registers.
  Assumes one 40 MHz clock; counter, tick, wrap and clock stamp come
  from the timer core on that clock; port pins are asynchronous.
*/
`timescale 1ns/100ps
`include "tic_regs.svh"

module tic_capture (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Port pins, asynchronous
  input  wire logic [`TIC_NPINS-1:0] port_zero,
  // Timer core, same clock
  input  wire tic_pkg::tic_cnt_t     current_count,
  input  wire logic                  timer_tick,
  input  wire logic                  timer_wrap,
  input  wire tic_pkg::tic_rtc_t     rtc_stamp,
  // Interrupt
  output logic                       irq
);
  import tic_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic tic_chcfg_t chan_cfg(input logic [`TIC_CFG_W-1:0] c,
                                          input int ch);
    chan_cfg = c[ch*`TIC_CH_W +: `TIC_CH_W];
  endfunction

  function automatic tic_cnt_t sat_dec(input tic_cnt_t v);
    sat_dec = (v == '0) ? '0 : tic_cnt_t'(v - 1'b1);
  endfunction

  function automatic tic_cnt_t sat_inc(input tic_cnt_t v);
    sat_inc = (v == '1) ? v : tic_cnt_t'(v + 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`TIC_CFG_W-1:0] cfg_q;
  logic                  unmask_q;
  logic                  tmr_pend_q;
  logic [1:0]            pend_q;
  logic [1:0]            ovr_q;
  tic_rtc_t              val_q [2];
  logic [`TIC_NPINS-1:0] pin_s1_q;
  logic [`TIC_NPINS-1:0] pin_s2_q;
  logic [1:0]            prev_q;
  tic_meas_e             st_q [2];
  logic [5:0]            per_q [2];
  tic_cnt_t              cyc_q [2];
  logic                  irq_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  tic_chcfg_t            chc [2];
  logic [1:0]            valid;
  logic [1:0]            lvl;
  logic [1:0]            ev;
  logic [1:0]            hit;
  logic [1:0]            clr;
  logic [1:0]            ien;
  tic_rtc_t              newval [2];
  logic                  wr_en;
  logic                  acc;
  logic [31:0]           rdata_d;
  logic                  err_d;

  assign acc   = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pwrite & pready_q;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= port_zero;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing and edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      chc[i]   = chan_cfg(cfg_q, i);
      valid[i] = (chc[i][`TIC_SEL_LSB +: `TIC_SEL_W] >= `TIC_PIN_LO) &&
                 (chc[i][`TIC_SEL_LSB +: `TIC_SEL_W] <= `TIC_PIN_HI);
      lvl[i]   = valid[i] &
                 pin_s2_q[4'(chc[i][`TIC_SEL_LSB +: `TIC_SEL_W] - 4'h1)];
      // Changing the pin routed may fake an edge
      ev[i]    = valid[i] & (chc[i][`TIC_FALL] ? (prev_q[i] & ~lvl[i])
                                              : (~prev_q[i] & lvl[i]));
      ien[i]   = chc[i][`TIC_IEN];
      clr[i]   = wr_en && (paddr == `TIC_OFS_CLR) && pwdata[`TIC_CLR_CH1 + i];
      hit[i]   = 1'b0;
      newval[i] = '0;
      if (chc[i][`TIC_MODE])
      begin
        // Window closes on the edge after limit+1 periods
        hit[i] = ev[i] && (st_q[i] == TIC_RUN) &&
                 (per_q[i] == chc[i][`TIC_PER_LSB +: `TIC_PER_W]);
        newval[i][`TIC_CNT_W-1:0] = sat_dec(cyc_q[i]);
      end
      else
      begin
        hit[i] = ev[i];
        newval[i][`TIC_RTC_W-1:`TIC_CNT_W] = rtc_stamp[`TIC_RTC_W-1:`TIC_CNT_W];
        newval[i][`TIC_CNT_W-1:0] = chc[i][`TIC_STAMP] ?
                                    rtc_stamp[`TIC_CNT_W-1:0] : current_count;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prev_q <= '0;
    else
      prev_q <= lvl;
  end

  // ----------------------------------------------------------------
  // Period counting
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!rst_n || !chc[i][`TIC_MODE] || !valid[i])
      begin
        st_q[i]  <= TIC_IDLE;
        per_q[i] <= '0;
        cyc_q[i] <= '0;
      end
      else
      begin
        case (st_q[i])
          TIC_IDLE:
          begin
            if (ev[i])
            begin
              st_q[i]  <= TIC_RUN;
              per_q[i] <= '0;
              cyc_q[i] <= tic_cnt_t'(timer_tick);
            end
          end
          TIC_RUN:
          begin
            if (hit[i])
            begin
              // Closing edge opens the next window; its tick belongs to it
              per_q[i] <= '0;
              cyc_q[i] <= tic_cnt_t'(timer_tick);
            end
            else
            begin
              if (ev[i])
                per_q[i] <= 6'(per_q[i] + 1'b1);
              if (timer_tick)
                cyc_q[i] <= sat_inc(cyc_q[i]);
            end
          end
          default:
            st_q[i] <= TIC_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel flags and values
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!rst_n)
      begin
        pend_q[i] <= 1'b0;
        ovr_q[i]  <= 1'b0;
        val_q[i]  <= '0;
      end
      else if (hit[i])
      begin
        // A new event beats a clear in the same cycle
        if (pend_q[i] && !clr[i])
          ovr_q[i] <= 1'b1;
        else
        begin
          pend_q[i] <= 1'b1;
          val_q[i]  <= newval[i];
          if (clr[i])
            ovr_q[i] <= 1'b0;
        end
      end
      else if (clr[i])
      begin
        pend_q[i] <= 1'b0;
        ovr_q[i]  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer flag, control and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tmr_pend_q <= 1'b0;
    else if (timer_wrap)
      tmr_pend_q <= 1'b1;
    else if (wr_en && (paddr == `TIC_OFS_CLR) && pwdata[`TIC_CLR_TMR])
      tmr_pend_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q    <= '0;
      unmask_q <= 1'b0;
    end
    else if (wr_en && (paddr == `TIC_OFS_CFG))
      cfg_q <= pwdata[`TIC_CFG_W-1:0];
    else if (wr_en && (paddr == `TIC_OFS_MASK))
      unmask_q <= pwdata[`TIC_MASK_TMR];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= (tmr_pend_q & unmask_q) | (|(pend_q & ien));
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = `TIC_RST_WORD;
    err_d   = 1'b0;
    if (paddr == `TIC_OFS_CFG)
      rdata_d[`TIC_CFG_W-1:0] = cfg_q;
    else if (paddr == `TIC_OFS_STAT)
    begin
      rdata_d[`TIC_CNT_W-1:0] = current_count;
      rdata_d[`TIC_ST_TMR]    = tmr_pend_q;
      rdata_d[`TIC_ST_PEND1 +: 2] = pend_q;
      rdata_d[`TIC_ST_OVR1 +: 2]  = ovr_q;
    end
    else if (paddr == `TIC_OFS_VAL1)
      rdata_d[`TIC_RTC_W-1:0] = val_q[0];
    else if (paddr == `TIC_OFS_VAL2)
      rdata_d[`TIC_RTC_W-1:0] = val_q[1];
    else if (paddr == `TIC_OFS_CLR)
      rdata_d = `TIC_RST_WORD;
    else if (paddr == `TIC_OFS_MASK)
    begin
      rdata_d[`TIC_MASK_TMR]      = unmask_q;
      rdata_d[`TIC_MASK_IEN1 +: 2] = ien;
    end
    else
      err_d = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= `TIC_RST_WORD;
      pslverr_q <= 1'b0;
    end
    else
    begin
      // One wait state keeps every bus output on a flip-flop
      pready_q  <= acc;
      prdata_q  <= (acc && !pwrite) ? rdata_d : `TIC_RST_WORD;
      pslverr_q <= acc & err_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_stat;
    psel && !penable && !pwrite && (paddr == `TIC_OFS_STAT) ##1 acc;
  endsequence

  property p_stat_count;
    s_read_stat |=> pready && (prdata[`TIC_CNT_W-1:0] == $past(current_count));
  endproperty
  a_stat_count: assert property (p_stat_count) else $error("status count wrong");

  property p_ready_wait;
    acc |=> pready ##1 !pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("bus answer late");

  property p_pend_hold;
    pend_q[0] && !clr[0] |=> pend_q[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending lost");

  property p_clr_ch;
    clr[1] && !hit[1] |=> !pend_q[1] && !ovr_q[1];
  endproperty
  a_clr_ch: assert property (p_clr_ch) else $error("channel clear failed");

  property p_overrun;
    pend_q[1] && hit[1] && !clr[1] |=> ovr_q[1] && $stable(val_q[1]);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun wrong");

  property p_tmr_set;
    timer_wrap |=> tmr_pend_q;
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("timer flag missed");

  property p_tmr_zero;
    tmr_pend_q && !timer_wrap && wr_en && (paddr == `TIC_OFS_CLR)
      && !pwdata[`TIC_CLR_TMR] |=> tmr_pend_q;
  endproperty
  a_tmr_zero: assert property (p_tmr_zero) else $error("zero write cleared");

  property p_pin_off;
    !valid[1] |-> !ev[1] ##1 !hit[1];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("unused pin fired");

  property p_cap_count;
    hit[0] && !pend_q[0] && !chc[0][`TIC_MODE] && !chc[0][`TIC_STAMP]
      |=> val_q[0][`TIC_CNT_W-1:0] == $past(current_count);
  endproperty
  a_cap_count: assert property (p_cap_count) else $error("capture value wrong");

  property p_irq_tmr;
    tmr_pend_q && !unmask_q && (pend_q == 2'b00) |=> !irq;
  endproperty
  a_irq_tmr: assert property (p_irq_tmr) else $error("masked timer irq");

  property p_irq_ch;
    pend_q[1] && ien[1] |=> irq;
  endproperty
  a_irq_ch: assert property (p_irq_ch) else $error("channel irq missing");
endmodule

//--- include/tic_regs.svh
/*
  Register map and field positions of the capture and period-count unit.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH

// ----------------------------------------------------------------
// Byte addresses on APB
// ----------------------------------------------------------------
`define TIC_OFS_CFG    32'h5000_4004
`define TIC_OFS_STAT   32'h5000_4008
`define TIC_OFS_VAL1   32'h5000_400c
`define TIC_OFS_VAL2   32'h5000_4010
`define TIC_OFS_CLR    32'h5000_4014
`define TIC_OFS_MASK   32'h5000_4018

// ----------------------------------------------------------------
// Channel configuration, relative to the channel base
// ----------------------------------------------------------------
`define TIC_CFG_W      28
`define TIC_CH_W       14
`define TIC_SEL_LSB    0
`define TIC_SEL_W      4
`define TIC_FALL       4
`define TIC_MODE       5
`define TIC_IEN        6
`define TIC_PER_LSB    7
`define TIC_PER_W      6
`define TIC_STAMP      13
`define TIC_PIN_LO     4'h1
`define TIC_PIN_HI     4'hc
`define TIC_NPINS      12

// ----------------------------------------------------------------
// Status, clear and mask fields
// ----------------------------------------------------------------
`define TIC_CNT_W      11
`define TIC_RTC_W      22
`define TIC_ST_TMR     11
`define TIC_ST_PEND1   12
`define TIC_ST_OVR1    14
`define TIC_CLR_TMR    0
`define TIC_CLR_CH1    1
`define TIC_MASK_TMR   11
`define TIC_MASK_IEN1  12
`define TIC_RST_WORD   32'h0000_0000

`endif

//--- include/tic_pkg.sv
/*
  Types shared by the capture and period-count unit.
  Assumes tic_regs.svh is on the include path.
*/
`include "tic_regs.svh"

package tic_pkg;
  typedef logic [`TIC_CNT_W-1:0] tic_cnt_t;
  typedef logic [`TIC_RTC_W-1:0] tic_rtc_t;
  typedef logic [`TIC_CH_W-1:0]  tic_chcfg_t;
  typedef enum logic [0:0]
  {
    TIC_IDLE = 1'b0,
    TIC_RUN  = 1'b1
  } tic_meas_e;
endpackage

//--- bench/tic_pins_model.sv
/*
  Far side of the capture unit: port pins and a small timer core model.
  Assumes the bench drives run and tick_div on the rising clock edge.
*/
`timescale 1ns/100ps

module tic_pins_model #(
  parameter int          WRAP_AT  = 100,
  parameter logic [21:0] RTC_INIT = 22'h2a_5c3
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Control from the bench
  input  wire logic          run,
  input  wire logic [1:0]    tick_div,
  // Pins and timer core
  output logic [11:0]        port_zero,
  output tic_pkg::tic_cnt_t  current_count,
  output logic               timer_tick,
  output logic               timer_wrap,
  output tic_pkg::tic_rtc_t  rtc_stamp
);
  import tic_pkg::*;

  logic [1:0] ph_q;

  initial port_zero = 12'h000;

  // ----------------------------------------------------------------
  // Timer core: frozen while run is low so stamps stay predictable
  // ----------------------------------------------------------------
  assign timer_tick = run && (ph_q == 2'h0);
  assign timer_wrap = timer_tick && (current_count == tic_cnt_t'(WRAP_AT - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ph_q <= 2'h0;
    else if (run)
      ph_q <= ((ph_q + 2'h1) >= tick_div) ? 2'h0 : ph_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      current_count <= '0;
    else if (timer_tick)
      current_count <= timer_wrap ? '0 : current_count + 11'h001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rtc_stamp <= RTC_INIT;
    else if (run)
      rtc_stamp <= rtc_stamp + 22'h00_0001;
  end

  // ----------------------------------------------------------------
  // Pins: toggle the masked pins n times, half cycles apart
  // ----------------------------------------------------------------
  task automatic wiggle(input logic [11:0] m, input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge clk);
      port_zero <= port_zero ^ m;
    end
  endtask
endmodule

//--- bench/timer_input_capture_count_tb.sv
/*
  Self-checking bench for the capture unit, driven over APB.
  Assumes tic_regs.svh on the include path and the pin model beside it.
*/
`timescale 1ns/100ps
`include "tic_regs.svh"

module timer_input_capture_count_tb;
  import tic_pkg::*;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        run, timer_tick, timer_wrap, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat, exp_v;
  logic [1:0]  tick_div;
  logic [11:0] port_zero;
  logic [3:0]  sels [4];
  tic_cnt_t    current_count;
  tic_rtc_t    rtc_stamp;
  int          n_mismatch, checked, n;

  tic_capture u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_zero(port_zero), .current_count(current_count),
    .timer_tick(timer_tick), .timer_wrap(timer_wrap), .rtc_stamp(rtc_stamp), .irq(irq));

  tic_pins_model u_pins (.clk(clk), .rst_n(rst_n), .run(run), .tick_div(tick_div),
    .port_zero(port_zero), .current_count(current_count), .timer_tick(timer_tick),
    .timer_wrap(timer_wrap), .rtc_stamp(rtc_stamp));

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting and comparison
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Counts: %0d checked, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // APB master: request held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] pready wait expected 1 seen %b", pready);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(nm, e, rdat);
  endtask

  task automatic wait_irq(input logic lvl);
    int k;
    k = 0;
    while (irq !== lvl && k < 40)
    begin
      @(posedge clk);
      k++;
    end
    chk_bit("irq", lvl, irq);
    if (irq !== lvl)
      tally_and_finish();
  endtask

  // Status word with the live count in the low bits
  function automatic logic [31:0] st(input logic [31:0] f);
    return f | {21'h0, current_count};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; run = 1'b0; tick_div = 2'h1;
    n_mismatch = 0; checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, access kinds and the unmapped address
    rd_chk("cfg", `TIC_OFS_CFG, 32'h0);
    rd_chk("status", `TIC_OFS_STAT, 32'h0);
    rd_chk("val1", `TIC_OFS_VAL1, 32'h0);
    rd_chk("val2", `TIC_OFS_VAL2, 32'h0);
    rd_chk("mask", `TIC_OFS_MASK, 32'h0);
    apb(1'b0, 32'h5000_4000, 32'h0);
    chk_bit("unmapped err", 1'b1, rerr);
    chk_word("unmapped data", 32'h0, rdat);
    wr(`TIC_OFS_CFG, 32'hffff_fff0);
    rd_chk("cfg", `TIC_OFS_CFG, 32'h0fff_fff0);
    wr(`TIC_OFS_MASK, 32'hffff_ffff);
    rd_chk("mask", `TIC_OFS_MASK, 32'h0000_3800);
    wr(`TIC_OFS_STAT, 32'hffff_ffff);
    rd_chk("status", `TIC_OFS_STAT, 32'h0);
    wr(`TIC_OFS_CLR, 32'h7);
    rd_chk("clr", `TIC_OFS_CLR, 32'h0);
    wr(`TIC_OFS_MASK, 32'h0);
    wr(`TIC_OFS_CFG, 32'h0);
    $display("test registers done");
    run <= 1'b1;
    repeat (37) @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    // Channel one capture of the counter on rising edges, several pins
    sels = '{4'h1, 4'h6, 4'hc, 4'h1};
    for (int i = 0; i < 3; i++)
    begin
      wr(`TIC_OFS_CFG, 32'h40 | sels[i]);
      u_pins.wiggle(12'h001 << (sels[i] - 4'h1), 2, 4);
      wait_irq(1'b1);
      exp_v = {10'h0, rtc_stamp[21:11], current_count};
      rd_chk("ch1 value", `TIC_OFS_VAL1, exp_v);
      rd_chk("status", `TIC_OFS_STAT, st(32'h1000));
      wr(`TIC_OFS_CLR, 32'h2);
      wait_irq(1'b0);
    end
    $display("test capture one done");
    // Channel two: falling edge, clock stamp, masked, then overrun
    wr(`TIC_OFS_CFG, 32'h0804_0000);
    wr(`TIC_OFS_CFG, 32'h0807_0000);
    u_pins.wiggle(12'h800, 2, 4);
    repeat (6) @(posedge clk);
    exp_v = {10'h0, rtc_stamp};
    chk_bit("irq masked", 1'b0, irq);
    rd_chk("status", `TIC_OFS_STAT, st(32'h2000));
    run <= 1'b1;
    repeat (5) @(posedge clk);
    run <= 1'b0;
    u_pins.wiggle(12'h800, 2, 4);
    repeat (6) @(posedge clk);
    rd_chk("status", `TIC_OFS_STAT, st(32'ha000));
    rd_chk("ch2 value", `TIC_OFS_VAL2, exp_v);
    wr(`TIC_OFS_CFG, 32'h0817_0000);
    wait_irq(1'b1);
    rd_chk("mask", `TIC_OFS_MASK, 32'h0000_2000);
    wr(`TIC_OFS_CLR, 32'h4);
    wait_irq(1'b0);
    rd_chk("status", `TIC_OFS_STAT, st(32'h0));
    wr(`TIC_OFS_CFG, 32'h0);
    $display("test capture two done");
    // Unused pin selects see no events
    sels = '{4'h0, 4'hd, 4'he, 4'hf};
    for (int i = 0; i < 4; i++)
    begin
      wr(`TIC_OFS_CFG, 32'h40 | sels[i]);
      u_pins.wiggle(12'hfff, 2, 4);
      repeat (6) @(posedge clk);
      chk_bit("irq unused pin", 1'b0, irq);
      rd_chk("status", `TIC_OFS_STAT, st(32'h0));
    end
    wr(`TIC_OFS_CFG, 32'h0);
    $display("test unused pins done");
    // Count mode: limit 2 over period 8, then limit 0 at half tick rate
    run <= 1'b1;
    wr(`TIC_OFS_CFG, 32'h0000_0161);
    u_pins.wiggle(12'h001, 8, 4);
    wait_irq(1'b1);
    rd_chk("ch1 count", `TIC_OFS_VAL1, 32'd23);
    wr(`TIC_OFS_CLR, 32'h2);
    wr(`TIC_OFS_CFG, 32'h0);
    tick_div <= 2'h2;
    wr(`TIC_OFS_CFG, 32'h0000_0061);
    u_pins.wiggle(12'h001, 4, 4);
    wait_irq(1'b1);
    rd_chk("ch1 count", `TIC_OFS_VAL1, 32'd3);
    wr(`TIC_OFS_CLR, 32'h2);
    wr(`TIC_OFS_CFG, 32'h0);
    wait_irq(1'b0);
    $display("test count mode done");
    // Timer flag, its clear and its mask
    wr(`TIC_OFS_CLR, 32'h1);
    n = 0;
    while (timer_wrap !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (timer_wrap !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] timer wrap wait expected 1 seen %b", timer_wrap);
      tally_and_finish();
    end
    run <= 1'b0;
    repeat (4) @(posedge clk);
    chk_bit("irq timer masked", 1'b0, irq);
    rd_chk("status", `TIC_OFS_STAT, st(32'h0800));
    wr(`TIC_OFS_CLR, 32'h0);
    rd_chk("status", `TIC_OFS_STAT, st(32'h0800));
    wr(`TIC_OFS_MASK, 32'h800);
    wait_irq(1'b1);
    rd_chk("mask", `TIC_OFS_MASK, 32'h0000_0800);
    wr(`TIC_OFS_CLR, 32'h1);
    wait_irq(1'b0);
    rd_chk("status", `TIC_OFS_STAT, st(32'h0));
    $display("test timer flag done");
    tally_and_finish();
  end
endmodule
